// >>> core/linefeed_supervision_pkg.sv
// Constants for the line-feed supervision register bank
package linefeed_supervision_pkg;

   // Register offsets, byte addresses on the 8-bit register port
   localparam logic [7:0] ADDR_LOOP_CURRENT_LIMIT = 8'h45;
   localparam logic [7:0] ADDR_DETECT_STATUS_CONTROL = 8'h46;
   localparam logic [7:0] ADDR_LOOP_CLOSURE_DEBOUNCE = 8'h47;
   localparam logic [7:0] ADDR_RING_TRIP_DEBOUNCE = 8'h48;
   localparam logic [7:0] ADDR_PWM_PERIOD = 8'h49;
   localparam logic [7:0] ADDR_CONVERTER_MIN_OFF_TIME = 8'h4A;
   localparam logic [7:0] ADDR_ON_HOOK_VOLTAGE = 8'h4C;
   localparam logic [7:0] ADDR_GROUND_MARGIN_VOLTAGE = 8'h4D;

   // Reset values
   localparam logic [7:0] RST_LOOP_CURRENT_LIMIT = 8'h00;
   localparam logic [2:0] RST_DETECT_CONTROL = 3'h0;
   localparam logic [7:0] RST_LOOP_CLOSURE_DEBOUNCE = 8'h00;
   localparam logic [7:0] RST_RING_TRIP_DEBOUNCE = 8'h00;
   localparam logic [7:0] RST_PWM_PERIOD = 8'hFF;
   localparam logic [7:0] RST_CONVERTER_MIN_OFF_TIME = 8'h76;
   localparam logic [7:0] RST_ON_HOOK_VOLTAGE = 8'h20;
   localparam logic [7:0] RST_GROUND_MARGIN_VOLTAGE = 8'h02;

   // Field positions
   localparam int LCL_CODE_LSB = 0;
   localparam int LCL_CM_LSB = 4;
   localparam int LCL_RING_RES_BIT = 6;
   localparam int LCL_TIP_RES_BIT = 7;
   localparam int DSC_CLOSURE_FILT_BIT = 0;
   localparam int DSC_TRIP_FILT_BIT = 1;
   localparam int DSC_CLOSURE_RAW_BIT = 2;
   localparam int DSC_TRIP_AC_BIT = 3;
   localparam int DSC_TRIP_DC_BIT = 4;
   localparam int DSC_VOLTAGE_MODE_BIT = 5;
   localparam int DSC_CLOSURE_MASK_BIT = 6;
   localparam int DSC_TRIP_MASK_BIT = 7;
   localparam int OHV_LEVEL_LSB = 0;
   localparam int OHV_POLARITY_BIT = 6;
   localparam int GMV_LEVEL_LSB = 0;
   localparam int GMV_UNBALANCED_BIT = 7;

   // Current limit scale in mA
   localparam logic [5:0] CURRENT_LIMIT_BASE_MA = 6'h14;
   localparam logic [5:0] CURRENT_LIMIT_STEP_MA = 6'h03;

   // Debounce step and system clock
   localparam int CLK_PERIOD_NS = 50;
   localparam int DEBOUNCE_STEP_NS = 1250000;
   localparam int DEBOUNCE_STEP_CYCLES = DEBOUNCE_STEP_NS / CLK_PERIOD_NS;

   // PLL period in system clock cycles, by {clock select, decimal bit clock}
   localparam logic [3:0] PLL_DIV_SEL0_BIN = 4'h1;
   localparam logic [3:0] PLL_DIV_SEL0_DEC = 4'h2;
   localparam logic [3:0] PLL_DIV_SEL1_BIN = 4'h2;
   localparam logic [3:0] PLL_DIV_SEL1_DEC = 4'h4;

endpackage

// >>> core/linefeed_supervision_regs.sv
// Line-feed supervision register bank with debounce and DC/DC PWM timing
// Operation
// - 3-bit current-limit code sets feed limit, 20 mA plus 3 mA per step.
// - Bits 6 and 7 of current-limit register switch ring and tip series resistors.
// - Status bit 0 shows debounced loop closure, zero otherwise.
// - Status bit 1 shows debounced ring trip, zero otherwise.
// - Status bit 2 shows the live loop-closure detector output.
// - Status bits 3 and 4 show live AC and DC ring-trip detector outputs.
// - Status bits 7:5 are read/write; bits 4:0 are read-only.
// - Bit 5 picks loop closure by current (zero) or voltage (one).
// - Bit 6 enables the loop-closure mask counter.
// - Bit 7 enables ring-trip masking.
// - 8-bit loop-closure debounce interval in 1.25 ms steps, reset zero.
// - Separate 8-bit ring-trip debounce interval in 1.25 ms steps, reset zero.
// - 8-bit PWM period register, reset all ones.
// - Minimum PWM off time is off-time code times PLL period, reset 0x76.
// - PLL period follows clock-select bit and binary or decimal bit clock.
// - Polarity bit picks forward or reverse for automatic transitions.
// - Automatic move to active uses the stored polarity bit.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
module linefeed_supervision_regs
   import linefeed_supervision_pkg::*;
#(
   parameter int DEBOUNCE_TICK_CYCLES = DEBOUNCE_STEP_CYCLES
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // Analog detector pins
   input wire logic closure_current_det,
   input wire logic closure_voltage_det,
   input wire logic trip_ac_det,
   input wire logic trip_dc_det,
   // Line state logic, same clock
   input wire logic closure_mask_window,
   input wire logic trip_mask_window,
   input wire logic auto_closure_en,
   input wire logic auto_trip_en,
   input wire logic converter_clock_select,
   input wire logic bclk_decimal,
   // Line-feed controls
   output logic [2:0] current_limit_code,
   output logic [5:0] current_limit_ma,
   output logic [1:0] common_mode_correction,
   output logic ring_series_resistor_on,
   output logic tip_series_resistor_on,
   output logic voltage_based_closure,
   output logic closure_mask_counter_en,
   output logic trip_mask_en,
   output logic loop_closure_filtered,
   output logic ring_trip_filtered,
   output logic [5:0] on_hook_level,
   output logic auto_polarity_select,
   output logic [5:0] ground_margin_level,
   output logic unbalanced_ringing_select,
   // DC/DC converter and automatic transitions
   output logic pwm_out,
   output logic active_request,
   output logic active_reverse
);

   logic [7:0] loop_current_limit;
   logic [7:0] closure_debounce_interval;
   logic [7:0] trip_debounce_interval;
   logic [7:0] pwm_period_code;
   logic [7:0] min_off_time_code;
   logic [7:0] on_hook_voltage;
   logic [7:0] ground_margin_voltage;
   logic [2:0] detect_control;

   // Detector pin synchronisers
   logic [3:0] det_pin;
   logic [3:0] det_meta;
   logic [3:0] det_sync;

   assign det_pin = {trip_dc_det, trip_ac_det, closure_voltage_det, closure_current_det};

   genvar gs;
   generate
      for (gs = 0; gs < 4; gs++) begin : g_sync
         always_ff @(posedge clk) begin
            if (rst) begin
               det_meta[gs] <= 1'b0;
               det_sync[gs] <= 1'b0;
            end else if (ce) begin
               det_meta[gs] <= det_pin[gs];
               det_sync[gs] <= det_meta[gs];
            end
         end
      end
   endgenerate

   // Register decode
   wire wr_lcl = wr && (addr == ADDR_LOOP_CURRENT_LIMIT);
   wire wr_dsc = wr && (addr == ADDR_DETECT_STATUS_CONTROL);
   wire wr_loop_closure_debounce = wr && (addr == ADDR_LOOP_CLOSURE_DEBOUNCE);
   wire wr_rtdb = wr && (addr == ADDR_RING_TRIP_DEBOUNCE);
   wire wr_pwm = wr && (addr == ADDR_PWM_PERIOD);
   wire wr_off = wr && (addr == ADDR_CONVERTER_MIN_OFF_TIME);
   wire wr_ohv = wr && (addr == ADDR_ON_HOOK_VOLTAGE);
   wire wr_gmv = wr && (addr == ADDR_GROUND_MARGIN_VOLTAGE);

   // Reserved bits are dropped on write so they read back as zero
   wire [7:0] lcl_mask = 8'hF7;
   wire [7:0] ohv_mask = 8'h7F;
   wire [7:0] gmv_mask = 8'hBF;

   always_ff @(posedge clk) begin
      if (rst) begin
         loop_current_limit <= RST_LOOP_CURRENT_LIMIT;
         detect_control <= RST_DETECT_CONTROL;
         closure_debounce_interval <= RST_LOOP_CLOSURE_DEBOUNCE;
         trip_debounce_interval <= RST_RING_TRIP_DEBOUNCE;
         pwm_period_code <= RST_PWM_PERIOD;
         min_off_time_code <= RST_CONVERTER_MIN_OFF_TIME;
         on_hook_voltage <= RST_ON_HOOK_VOLTAGE;
         ground_margin_voltage <= RST_GROUND_MARGIN_VOLTAGE;
      end else if (ce) begin
         if (wr_lcl) loop_current_limit <= wdata & lcl_mask;
         if (wr_dsc) detect_control <= wdata[7:5];
         if (wr_loop_closure_debounce) closure_debounce_interval <= wdata;
         if (wr_rtdb) trip_debounce_interval <= wdata;
         if (wr_pwm) pwm_period_code <= wdata;
         if (wr_off) min_off_time_code <= wdata;
         if (wr_ohv) on_hook_voltage <= wdata & ohv_mask;
         if (wr_gmv) ground_margin_voltage <= wdata & gmv_mask;
      end
   end

   // Field outputs, all straight from register flops
   assign current_limit_code = loop_current_limit[LCL_CODE_LSB +: 3];
   assign common_mode_correction = loop_current_limit[LCL_CM_LSB +: 2];
   assign ring_series_resistor_on = loop_current_limit[LCL_RING_RES_BIT];
   assign tip_series_resistor_on = loop_current_limit[LCL_TIP_RES_BIT];
   assign voltage_based_closure = detect_control[DSC_VOLTAGE_MODE_BIT - 5];
   assign closure_mask_counter_en = detect_control[DSC_CLOSURE_MASK_BIT - 5];
   assign trip_mask_en = detect_control[DSC_TRIP_MASK_BIT - 5];
   assign on_hook_level = on_hook_voltage[OHV_LEVEL_LSB +: 6];
   assign auto_polarity_select = on_hook_voltage[OHV_POLARITY_BIT];
   assign ground_margin_level = ground_margin_voltage[GMV_LEVEL_LSB +: 6];
   assign unbalanced_ringing_select = ground_margin_voltage[GMV_UNBALANCED_BIT];

   // Current limit in mA, registered to keep the output flop-driven
   wire [5:0] next_current_limit_ma = CURRENT_LIMIT_BASE_MA
      + 6'(CURRENT_LIMIT_STEP_MA * {3'h0, current_limit_code});

   always_ff @(posedge clk) begin
      if (rst) current_limit_ma <= CURRENT_LIMIT_BASE_MA;
      else if (ce) current_limit_ma <= next_current_limit_ma;
   end

   // Detector selection
   wire closure_raw = voltage_based_closure ? det_sync[1] : det_sync[0];
   wire trip_raw = det_sync[2] | det_sync[3];

   // Shared 1.25 ms tick; a debounce may run up to one tick short of its nominal length
   logic [15:0] step_cnt;
   wire step_tick = (step_cnt == 16'(DEBOUNCE_TICK_CYCLES - 1));

   always_ff @(posedge clk) begin
      if (rst) step_cnt <= 16'h0000;
      else if (ce) step_cnt <= step_tick ? 16'h0000 : step_cnt + 16'h0001;
   end

   // Debounce, entry 0 is loop closure, entry 1 is ring trip
   logic [1:0] deb_raw;
   logic [1:0] deb_hold;
   logic [1:0] deb_filt;
   logic [7:0] deb_interval [2];
   logic [7:0] deb_cnt [2];

   assign deb_raw = {trip_raw, closure_raw};
   assign deb_hold = {trip_mask_en & trip_mask_window,
                      closure_mask_counter_en & closure_mask_window};
   assign deb_interval[0] = closure_debounce_interval;
   assign deb_interval[1] = trip_debounce_interval;

   genvar gd;
   generate
      for (gd = 0; gd < 2; gd++) begin : g_debounce
         always_ff @(posedge clk) begin
            if (rst) begin
               deb_cnt[gd] <= 8'h00;
               deb_filt[gd] <= 1'b0;
            end else if (ce) begin
               if (!deb_raw[gd]) begin
                  deb_cnt[gd] <= 8'h00;
                  deb_filt[gd] <= 1'b0;
               end else if (deb_hold[gd]) begin
                  deb_cnt[gd] <= deb_cnt[gd];
               end else if (deb_cnt[gd] >= deb_interval[gd]) begin
                  deb_filt[gd] <= 1'b1;
               end else if (step_tick) begin
                  deb_cnt[gd] <= deb_cnt[gd] + 8'h01;
               end
            end
         end
      end
   endgenerate

   assign loop_closure_filtered = deb_filt[0];
   assign ring_trip_filtered = deb_filt[1];

   // Automatic move to active on a fresh filtered detection
   logic [1:0] filt_prev;
   wire auto_go = (deb_filt[0] & ~filt_prev[0] & auto_closure_en)
                | (deb_filt[1] & ~filt_prev[1] & auto_trip_en);

   always_ff @(posedge clk) begin
      if (rst) begin
         filt_prev <= 2'b00;
         active_request <= 1'b0;
         active_reverse <= 1'b0;
      end else if (ce) begin
         filt_prev <= deb_filt;
         active_request <= auto_go;
         if (auto_go) active_reverse <= auto_polarity_select;
      end
   end

   // PLL period tick for the converter timing
   logic [3:0] pll_cnt;
   wire [3:0] pll_div = converter_clock_select
      ? (bclk_decimal ? PLL_DIV_SEL1_DEC : PLL_DIV_SEL1_BIN)
      : (bclk_decimal ? PLL_DIV_SEL0_DEC : PLL_DIV_SEL0_BIN);
   wire pll_tick = (pll_cnt >= pll_div - 4'h1);

   always_ff @(posedge clk) begin
      if (rst) pll_cnt <= 4'h0;
      else if (ce) pll_cnt <= pll_tick ? 4'h0 : pll_cnt + 4'h1;
   end

   // Off-time run in PLL periods; a rise waits for it, but an off-time write in the cycle of a rise only takes effect after that rise
   logic [8:0] off_run;
   wire off_done = ({1'b0, off_run} + 10'h001 >= {2'b00, min_off_time_code});
   always_ff @(posedge clk) begin
      if (rst) off_run <= 9'h000;
      else if (ce && pwm_out) off_run <= 9'h000;
      else if (ce && pll_tick && off_run != 9'h1FF) off_run <= off_run + 9'h001;
   end

   // PWM: on for period minus off time, then low for at least the off time
   logic [7:0] pwm_cnt;
   // A period not above the off time keeps the switch off, never shortens the off time
   wire [7:0] on_len = (pwm_period_code > min_off_time_code)
      ? pwm_period_code - min_off_time_code : 8'h00;
   wire pwm_wrap = (pwm_cnt >= pwm_period_code - 8'h01);
   wire [7:0] next_pwm_cnt = pwm_wrap ? 8'h00 : pwm_cnt + 8'h01;

   always_ff @(posedge clk) begin
      if (rst) begin
         pwm_cnt <= 8'h00;
         pwm_out <= 1'b0;
      end else if (ce && pll_tick) begin
         pwm_cnt <= next_pwm_cnt;
         pwm_out <= (next_pwm_cnt < on_len) && (pwm_out || off_done);
      end
   end

   // Read data, valid only in the cycle after the strobe
   wire [7:0] status_word = {detect_control, det_sync[3], det_sync[2], closure_raw,
                             deb_filt[1], deb_filt[0]};
   wire [7:0] next_rdata =
        (addr == ADDR_LOOP_CURRENT_LIMIT) ? loop_current_limit
      : (addr == ADDR_DETECT_STATUS_CONTROL) ? status_word
      : (addr == ADDR_LOOP_CLOSURE_DEBOUNCE) ? closure_debounce_interval
      : (addr == ADDR_RING_TRIP_DEBOUNCE) ? trip_debounce_interval
      : (addr == ADDR_PWM_PERIOD) ? pwm_period_code
      : (addr == ADDR_CONVERTER_MIN_OFF_TIME) ? min_off_time_code
      : (addr == ADDR_ON_HOOK_VOLTAGE) ? on_hook_voltage
      : (addr == ADDR_GROUND_MARGIN_VOLTAGE) ? ground_margin_voltage
      : 8'h00;

   always_ff @(posedge clk) begin
      if (rst) rdata <= 8'h00;
      else if (ce) rdata <= rd ? next_rdata : 8'h00;
   end

   property p_resistor_write;
      @(posedge clk) disable iff (rst)
      ce && wr_lcl |=> ring_series_resistor_on == $past(wdata[6]) && tip_series_resistor_on == $past(wdata[7]);
   endproperty
   a_resistor_write: assert property (p_resistor_write) else $error("series resistor bit not stored");

   property p_status_ro;
      @(posedge clk) disable iff (rst)
      ce && wr_dsc ##1 ce && rd && addr == ADDR_DETECT_STATUS_CONTROL
      |=> rdata[7:5] == $past(wdata[7:5], 2) && rdata[1:0] == $past(deb_filt);
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status low bits changed by write");

   property p_raw_read;
      @(posedge clk) disable iff (rst)
      ce && rd && addr == ADDR_DETECT_STATUS_CONTROL
      |=> rdata[2] == $past(closure_raw) && rdata[3] == $past(det_sync[2]) && rdata[4] == $past(det_sync[3]);
   endproperty
   a_raw_read: assert property (p_raw_read) else $error("raw detector bits misread");

   property p_voltage_mode;
      @(posedge clk) disable iff (rst)
      ce && voltage_based_closure && !det_sync[1] |=> !loop_closure_filtered;
   endproperty
   a_voltage_mode: assert property (p_voltage_mode) else $error("closure set without voltage detection");

   property p_trip_drop;
      @(posedge clk) disable iff (rst)
      ce && !trip_raw |=> !ring_trip_filtered && deb_cnt[1] == 8'h00;
   endproperty
   a_trip_drop: assert property (p_trip_drop) else $error("trip flag survived raw drop");

   property p_closure_hold;
      @(posedge clk) disable iff (rst)
      ce && closure_raw && closure_mask_counter_en && closure_mask_window |=> deb_cnt[0] == $past(deb_cnt[0]);
   endproperty
   a_closure_hold: assert property (p_closure_hold) else $error("closure count moved while masked");

   property p_trip_hold;
      @(posedge clk) disable iff (rst)
      ce && trip_raw && trip_mask_en && trip_mask_window |=> deb_cnt[1] == $past(deb_cnt[1]);
   endproperty
   a_trip_hold: assert property (p_trip_hold) else $error("trip count moved while masked");

   property p_off_time;
      @(posedge clk) disable iff (rst)
      $rose(pwm_out) |-> off_run >= {1'b0, min_off_time_code} || $past(wr_off);
   endproperty
   a_off_time: assert property (p_off_time) else $error("pwm off time too short");

   property p_pwm_wrap;
      @(posedge clk) disable iff (rst)
      ce && pll_tick && pwm_period_code != 8'h00 && pwm_cnt >= pwm_period_code - 8'h01 |=> pwm_cnt == 8'h00;
   endproperty
   a_pwm_wrap: assert property (p_pwm_wrap) else $error("pwm period not honoured");

   property p_auto_polarity;
      @(posedge clk) disable iff (rst)
      active_request |-> active_reverse == $past(auto_polarity_select);
   endproperty
   a_auto_polarity: assert property (p_auto_polarity) else $error("active polarity wrong");

endmodule

// >>> tb/linefeed_supervision_regs_tb.sv
// Self-checking bench for the line-feed supervision register bank
`timescale 1ns/100ps
module linefeed_supervision_regs_tb;
   import linefeed_supervision_pkg::*;
   localparam int TICK = 10;
   logic clk, rst, ce, wr, rd;
   logic [7:0] addr, wdata, rdata, d;
   logic closure_current_det, closure_voltage_det, trip_ac_det, trip_dc_det;
   logic closure_mask_window, trip_mask_window, auto_closure_en, auto_trip_en;
   logic converter_clock_select, bclk_decimal;
   logic [2:0] current_limit_code;
   logic [5:0] current_limit_ma, on_hook_level, ground_margin_level;
   logic [1:0] common_mode_correction;
   logic ring_series_resistor_on, tip_series_resistor_on, voltage_based_closure;
   logic closure_mask_counter_en, trip_mask_en, loop_closure_filtered, ring_trip_filtered;
   logic auto_polarity_select, unbalanced_ringing_select, pwm_out, active_request, active_reverse;
   int fail_count = 0;
   int n_compared = 0;
   int cycles = 0;

   // Short debounce tick keeps the run brief
   linefeed_supervision_regs #(.DEBOUNCE_TICK_CYCLES(TICK)) u_linefeed_supervision_regs (
      .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .closure_current_det(closure_current_det), .closure_voltage_det(closure_voltage_det),
      .trip_ac_det(trip_ac_det), .trip_dc_det(trip_dc_det),
      .closure_mask_window(closure_mask_window), .trip_mask_window(trip_mask_window),
      .auto_closure_en(auto_closure_en), .auto_trip_en(auto_trip_en),
      .converter_clock_select(converter_clock_select), .bclk_decimal(bclk_decimal),
      .current_limit_code(current_limit_code), .current_limit_ma(current_limit_ma),
      .common_mode_correction(common_mode_correction), .ring_series_resistor_on(ring_series_resistor_on),
      .tip_series_resistor_on(tip_series_resistor_on), .voltage_based_closure(voltage_based_closure),
      .closure_mask_counter_en(closure_mask_counter_en), .trip_mask_en(trip_mask_en),
      .loop_closure_filtered(loop_closure_filtered), .ring_trip_filtered(ring_trip_filtered),
      .on_hook_level(on_hook_level), .auto_polarity_select(auto_polarity_select),
      .ground_margin_level(ground_margin_level), .unbalanced_ringing_select(unbalanced_ringing_select),
      .pwm_out(pwm_out), .active_request(active_request), .active_reverse(active_reverse));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic final_report();
      if (fail_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Hang guard, generous against the expected run of under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         final_report();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   wire [2:0] flags = {active_request, ring_trip_filtered, loop_closure_filtered};

   // Counts settled cycles until a flag rises, bounded
   task automatic wait_flag(input int sel, input int lim, output int n);
      n = 0;
      while (flags[sel] !== 1'b1 && n < lim) begin
         @(posedge clk);
         #1 n++;
      end
   endtask

   task automatic t_reset_values();
      logic [7:0] a [9] = '{8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h4D};
      logic [7:0] e [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h76, 8'h00, 8'h20, 8'h02};
      for (int i = 0; i < 9; i++) begin
         rd_reg(a[i], d);
         check(d, e[i]);
      end
      @(posedge clk);
      #1 check(rdata, 8'h00);
      check({2'h0, current_limit_ma}, 8'h14);
   endtask

   task automatic t_current_limit();
      logic [7:0] v;
      for (int c = 0; c < 8; c++) begin
         v = {c[0], ~c[0], c[1:0], 1'b1, c[2:0]};
         wr_reg(ADDR_LOOP_CURRENT_LIMIT, v);
         rd_reg(ADDR_LOOP_CURRENT_LIMIT, d);
         check(d, v & 8'hF7);
         check({5'h00, current_limit_code}, 8'(c));
         check({2'h0, current_limit_ma}, 8'(20 + 3 * c));
         check({tip_series_resistor_on, ring_series_resistor_on, common_mode_correction}, v[7:4]);
      end
   endtask

   task automatic t_plain_regs();
      // Write then read with no gap between the strobes
      @(posedge clk);
      addr <= ADDR_DETECT_STATUS_CONTROL;
      wdata <= 8'hFF;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, 8'hE0);
      check({trip_mask_en, closure_mask_counter_en, voltage_based_closure}, 8'h07);
      wr_reg(ADDR_DETECT_STATUS_CONTROL, 8'h00);
      wr_reg(ADDR_ON_HOOK_VOLTAGE, 8'hFF);
      rd_reg(ADDR_ON_HOOK_VOLTAGE, d);
      check(d, 8'h7F);
      check({auto_polarity_select, on_hook_level}, 8'h7F);
      wr_reg(ADDR_GROUND_MARGIN_VOLTAGE, 8'hFF);
      rd_reg(ADDR_GROUND_MARGIN_VOLTAGE, d);
      check(d, 8'hBF);
      check({unbalanced_ringing_select, 1'b0, ground_margin_level}, 8'hBF);
      wr_reg(8'h4B, 8'h5A);
      rd_reg(8'h4B, d);
      check(d, 8'h00);
      wr_reg(ADDR_RING_TRIP_DEBOUNCE, 8'hA5);
      rd_reg(ADDR_RING_TRIP_DEBOUNCE, d);
      check(d, 8'hA5);
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(ADDR_LOOP_CLOSURE_DEBOUNCE, 8'h33);
      ce <= 1'b1;
      rd_reg(ADDR_LOOP_CLOSURE_DEBOUNCE, d);
      check(d, 8'h00);
   endtask

   // Long intervals keep the filtered flags out of the way
   task automatic t_raw_status();
      wr_reg(ADDR_LOOP_CLOSURE_DEBOUNCE, 8'hFF);
      wr_reg(ADDR_RING_TRIP_DEBOUNCE, 8'hFF);
      closure_current_det <= 1'b1;
      trip_ac_det <= 1'b1;
      cyc(3);
      rd_reg(ADDR_DETECT_STATUS_CONTROL, d);
      check(d, 8'h0C);
      wr_reg(ADDR_DETECT_STATUS_CONTROL, 8'h3F);
      rd_reg(ADDR_DETECT_STATUS_CONTROL, d);
      check(d, 8'h28);
      closure_voltage_det <= 1'b1;
      closure_current_det <= 1'b0;
      trip_ac_det <= 1'b0;
      trip_dc_det <= 1'b1;
      cyc(3);
      rd_reg(ADDR_DETECT_STATUS_CONTROL, d);
      check(d, 8'h34);
      closure_voltage_det <= 1'b0;
      trip_dc_det <= 1'b0;
      wr_reg(ADDR_DETECT_STATUS_CONTROL, 8'h00);
      cyc(4);
   endtask

   task automatic t_debounce_auto();
      int n;
      wr_reg(ADDR_LOOP_CLOSURE_DEBOUNCE, 8'h03);
      wr_reg(ADDR_ON_HOOK_VOLTAGE, 8'h60);
      auto_closure_en <= 1'b1;
      closure_current_det <= 1'b1;
      wait_flag(0, 100, n);
      check(8'(n >= 23 && n <= 34), 8'h01);
      wait_flag(2, 3, n);
      check({6'h00, active_request, active_reverse}, 8'h03);
      rd_reg(ADDR_DETECT_STATUS_CONTROL, d);
      check(d, 8'h05);
      closure_current_det <= 1'b0;
      cyc(4);
      #1 check({7'h00, loop_closure_filtered}, 8'h00);
      wr_reg(ADDR_RING_TRIP_DEBOUNCE, 8'h00);
      wr_reg(ADDR_ON_HOOK_VOLTAGE, 8'h20);
      auto_trip_en <= 1'b1;
      trip_dc_det <= 1'b1;
      wait_flag(1, 6, n);
      check({7'h00, ring_trip_filtered}, 8'h01);
      wait_flag(2, 3, n);
      check({6'h00, active_request, active_reverse}, 8'h02);
      rd_reg(ADDR_DETECT_STATUS_CONTROL, d);
      check(d, 8'h12);
      trip_dc_det <= 1'b0;
      auto_closure_en <= 1'b0;
      auto_trip_en <= 1'b0;
      cyc(4);
   endtask

   task automatic t_masks();
      int n;
      wr_reg(ADDR_LOOP_CLOSURE_DEBOUNCE, 8'h00);
      wr_reg(ADDR_DETECT_STATUS_CONTROL, 8'hC0);
      closure_mask_window <= 1'b1;
      trip_mask_window <= 1'b1;
      closure_current_det <= 1'b1;
      trip_ac_det <= 1'b1;
      cyc(12);
      #1 check({6'h00, loop_closure_filtered, ring_trip_filtered}, 8'h00);
      closure_mask_window <= 1'b0;
      trip_mask_window <= 1'b0;
      wait_flag(0, 6, n);
      check({6'h00, loop_closure_filtered, ring_trip_filtered}, 8'h03);
      closure_current_det <= 1'b0;
      trip_ac_det <= 1'b0;
      wr_reg(ADDR_DETECT_STATUS_CONTROL, 8'h00);
   endtask

   task automatic count_level(input logic lvl, output int n);
      n = 0;
      while (pwm_out === lvl && n < 600) begin
         @(posedge clk);
         #1 n++;
      end
   endtask

   task automatic t_pwm();
      int div [4] = '{PLL_DIV_SEL0_BIN, PLL_DIV_SEL0_DEC, PLL_DIV_SEL1_BIN, PLL_DIV_SEL1_DEC};
      int hi, lo;
      wr_reg(ADDR_PWM_PERIOD, 8'h0A);
      wr_reg(ADDR_CONVERTER_MIN_OFF_TIME, 8'h04);
      for (int i = 0; i < 4; i++) begin
         converter_clock_select <= i[1];
         bclk_decimal <= i[0];
         cyc(50);
         count_level(1'b1, hi);
         count_level(1'b0, lo);
         count_level(1'b1, hi);
         count_level(1'b0, lo);
         check(8'(hi), 8'(6 * div[i]));
         check(8'(lo), 8'(4 * div[i]));
      end
   endtask

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      {wr, rd, addr, wdata} = '0;
      {closure_current_det, closure_voltage_det, trip_ac_det, trip_dc_det} = '0;
      {closure_mask_window, trip_mask_window, auto_closure_en, auto_trip_en} = '0;
      {converter_clock_select, bclk_decimal} = '0;
      cyc(5);
      rst <= 1'b0;
      t_reset_values();
      t_current_limit();
      t_plain_regs();
      t_raw_status();
      t_debounce_auto();
      t_masks();
      t_pwm();
      final_report();
   end
endmodule
